// file: hw/rxg_bank.sv
// Purpose: AXI4-Lite bank of three receiver configuration registers with squelch timing
// Assumes: TX end, frame, pulse and timer-match strobes come from logic on CLK
// Notes: one write and one read at a time; both can be answered in parallel
`timescale 1ns/100ps
`include "rxg_params.svh"
module rxg_bank
   import rxg_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // AXI4-Lite write
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Receiver events
   input wire logic TX_END,
   input wire logic RX_FRAME,
   input wire logic SUBCARRIER_PULSE,
   input wire logic SQ_STOP_MATCH,
   input wire logic RESET_RX_GAIN_CMD,
   // Analog controls
   output logic SQUELCH_ACTIVE,
   output logic GAIN_LOOP_RUN,
   output rxg_ctl_s RX_CTL,
   output logic [2:0] AM_STAGE1_GAIN,
   output logic [2:0] PM_STAGE1_GAIN,
   output rxg_s23_s AM_STAGE23,
   output rxg_s23_s PM_STAGE23,
   output logic [7:0] STAGE23_LOADED
);

   rxg_state_s s_q;
   rxg_state_s s_d;

   function automatic logic [1:0] addr_sel(input logic [7:0] a);
      // Byte address to slot: 1..3, 0 when unmapped
      if (a == (`RXG_IDX_DEMOD << 2)) addr_sel = 2'd1;
      else if (a == (`RXG_IDX_STAGE1 << 2)) addr_sel = 2'd2;
      else if (a == (`RXG_IDX_STAGE23 << 2)) addr_sel = 2'd3;
      else addr_sel = 2'd0;
   endfunction

   function automatic rxg_s23_s dec_s23(input logic [3:0] c);
      dec_s23.invalid = (c > `RXG_STAGE23_MAX);
      dec_s23.widen_steps = (c > `RXG_STAGE23_WIDEN_MAX) ? `RXG_STAGE23_WIDEN_MAX : c;
      dec_s23.stage_cut_steps = (c > `RXG_STAGE23_WIDEN_MAX) ?
         4'(c - `RXG_STAGE23_WIDEN_MAX) : 4'h0;
   endfunction

   logic aw_ok;
   logic w_ok;
   logic do_write;
   logic [1:0] wsel;
   logic [1:0] rsel;
   logic [7:0] aw_a;
   logic [7:0] w_v;
   logic w_lane0;

   assign AWREADY = !s_q.aw_hold && !s_q.bvalid;
   assign WREADY = !s_q.w_hold && !s_q.bvalid;
   assign ARREADY = !s_q.rvalid;

   always_comb begin
      aw_ok = s_q.aw_hold || (AWVALID && AWREADY);
      w_ok = s_q.w_hold || (WVALID && WREADY);
      do_write = aw_ok && w_ok && !s_q.bvalid;
      aw_a = s_q.aw_hold ? s_q.aw_addr : AWADDR;
      w_v = s_q.w_hold ? s_q.w_data : WDATA[7:0];
      w_lane0 = s_q.w_hold ? s_q.w_strb[0] : WSTRB[0];
      wsel = addr_sel(aw_a);
      rsel = addr_sel(ARADDR);
   end

   always_comb begin
      s_d = s_q;
      // Address and data may arrive in either order
      if (AWVALID && AWREADY && !do_write) begin
         s_d.aw_hold = 1'b1;
         s_d.aw_addr = AWADDR;
      end
      if (WVALID && WREADY && !do_write) begin
         s_d.w_hold = 1'b1;
         s_d.w_data = WDATA[7:0];
         s_d.w_strb = WSTRB;
      end
      if (do_write) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = (wsel == 2'd0) ? `RXG_RESP_SLVERR : `RXG_RESP_OKAY;
         if (w_lane0) begin
            case (wsel)
               2'd1: s_d.demod = w_v;
               2'd2: s_d.stage1 = w_v;
               // Held back from AGC/squelch/RSSI until the load command
               2'd3: s_d.stage23 = w_v;
               default: ;
            endcase
         end
      end else if (s_q.bvalid && BREADY) begin
         s_d.bvalid = 1'b0;
      end
      if (ARVALID && ARREADY) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = (rsel == 2'd0) ? `RXG_RESP_SLVERR : `RXG_RESP_OKAY;
         case (rsel)
            2'd1: s_d.rdata = s_q.demod;
            2'd2: s_d.rdata = s_q.stage1;
            2'd3: s_d.rdata = s_q.stage23;
            default: s_d.rdata = 8'h00;
         endcase
      end else if (s_q.rvalid && RREADY) begin
         s_d.rvalid = 1'b0;
      end
      // Command copies the register into the loop blocks
      if (RESET_RX_GAIN_CMD) begin
         s_d.stage23_live = s_q.stage23;
      end
      // Squelch sequencer; a TX end is taken only in idle, so one during the delay or while on is ignored
      case (s_q.sq)
         RXG_SQ_IDLE: begin
            if (TX_END && s_q.demod[`RXG_B_SQ_EN]) begin
               s_d.sq = RXG_SQ_WAIT;
               s_d.sq_cnt = 10'd1;
            end
         end
         RXG_SQ_WAIT: begin
            s_d.sq_cnt = 10'(s_q.sq_cnt + 10'd1);
            if (s_q.sq_cnt >= 10'(`RXG_SQ_DELAY_CYC)) begin
               s_d.sq = RXG_SQ_ON;
            end
         end
         RXG_SQ_ON: begin
            if (SQ_STOP_MATCH) begin
               s_d.sq = RXG_SQ_IDLE;
            end
         end
         default: s_d.sq = RXG_SQ_IDLE;
      endcase
      if (!s_q.demod[`RXG_B_SQ_EN]) begin
         s_d.sq = RXG_SQ_IDLE;
         s_d.sq_cnt = 10'd0;
      end
      // Gain loop window: eight pulses or the whole frame
      if (!RX_FRAME || !s_q.demod[`RXG_B_GL_EN]) begin
         s_d.gl_pulses = 4'h0;
         s_d.gl_run = RX_FRAME && s_q.demod[`RXG_B_GL_EN];
      end else begin
         if (!s_q.gl_run && s_q.gl_pulses == 4'h0) begin
            s_d.gl_run = 1'b1;
         end
         if (SUBCARRIER_PULSE && s_q.gl_pulses != 4'(`RXG_GL_PULSES)) begin
            s_d.gl_pulses = 4'(s_q.gl_pulses + 4'h1);
         end
         if (!s_q.demod[`RXG_B_GL_WIN] && SUBCARRIER_PULSE &&
             s_q.gl_pulses == 4'(`RXG_GL_PULSES - 1)) begin
            s_d.gl_run = 1'b0;
         end
      end
      if (!RST_B) begin
         s_d = '0;
         s_d.demod = `RXG_RST_DEMOD;
         s_d.stage1 = `RXG_RST_STAGE1;
         s_d.stage23 = `RXG_RST_STAGE23;
         s_d.stage23_live = `RXG_RST_STAGE23;
         s_d.sq = RXG_SQ_IDLE;
      end
   end

   always_ff @(posedge CLK) begin
      s_q <= s_d;
   end

   assign BVALID = s_q.bvalid;
   assign BRESP = s_q.bresp;
   assign RVALID = s_q.rvalid;
   assign RRESP = s_q.rresp;
   assign RDATA = {24'h000000, s_q.rdata};
   assign SQUELCH_ACTIVE = (s_q.sq == RXG_SQ_ON);
   assign GAIN_LOOP_RUN = s_q.gl_run;
   always_comb begin
      RX_CTL.iq_mode = s_q.demod[`RXG_B_DEMOD_MODE];
      // Peak detector cannot feed I/Q; flagged, not corrected
      RX_CTL.iq_invalid = s_q.demod[`RXG_B_DEMOD_MODE] && !s_q.demod[`RXG_B_AMD_SEL];
      RX_CTL.sq_ratio_6_3 = s_q.demod[`RXG_B_SQ_RATIO];
      RX_CTL.gl_active = s_q.demod[`RXG_B_GL_EN];
      RX_CTL.gl_whole_frame = s_q.demod[`RXG_B_GL_WIN];
      RX_CTL.gl_alg_reset = s_q.demod[`RXG_B_GL_ALG];
      RX_CTL.gl_ratio_6 = s_q.demod[`RXG_B_GL_RATIO];
      RX_CTL.hf_route = !s_q.stage1[`RXG_B_LOW_FREQ_INPUT_ENABLE];
      RX_CTL.lf_route = s_q.stage1[`RXG_B_LOW_FREQ_INPUT_ENABLE];
      RX_CTL.lf_split_ab = s_q.stage1[`RXG_B_LF_SPLIT];
   end
   assign AM_STAGE1_GAIN = s_q.stage1[7:5];
   assign PM_STAGE1_GAIN = s_q.stage1[4:2];
   assign AM_STAGE23 = dec_s23(s_q.stage23_live[7:4]);
   assign PM_STAGE23 = dec_s23(s_q.stage23_live[3:0]);
   assign STAGE23_LOADED = s_q.stage23_live;

   chk_bvalid_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   chk_rvalid_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   chk_stage23_defer: assert property (@(posedge CLK) disable iff (!RST_B)
      !RESET_RX_GAIN_CMD |=> $stable(STAGE23_LOADED))
      else $error("stage23 live value changed without command");
   chk_stage23_load: assert property (@(posedge CLK) disable iff (!RST_B)
      RESET_RX_GAIN_CMD |=> STAGE23_LOADED == $past(s_q.stage23))
      else $error("stage23 load wrong");
   // Start must come inside the delay window; the exact count is checked next
   chk_squelch_delay: assert property (@(posedge CLK) disable iff (!RST_B)
      s_q.sq == RXG_SQ_IDLE && TX_END && s_q.demod[`RXG_B_SQ_EN] |->
      ##[1:379] (SQUELCH_ACTIVE || !s_q.demod[`RXG_B_SQ_EN]))
      else $error("squelch did not start in time");
   chk_squelch_early: assert property (@(posedge CLK) disable iff (!RST_B)
      $rose(SQUELCH_ACTIVE) |-> $past(s_q.sq_cnt) == 10'd378)
      else $error("squelch started at wrong count");
   chk_squelch_off: assert property (@(posedge CLK) disable iff (!RST_B)
      !s_q.demod[`RXG_B_SQ_EN] |=> !SQUELCH_ACTIVE)
      else $error("squelch active while disabled");
   chk_iq_flag: assert property (@(posedge CLK) disable iff (!RST_B)
      RX_CTL.iq_invalid |-> RX_CTL.iq_mode && !s_q.demod[`RXG_B_AMD_SEL])
      else $error("iq flag wrong");
   chk_gl_enable: assert property (@(posedge CLK) disable iff (!RST_B)
      GAIN_LOOP_RUN |-> $past(s_q.demod[`RXG_B_GL_EN]))
      else $error("gain loop ran disabled");
   chk_gl_window: assert property (@(posedge CLK) disable iff (!RST_B)
      s_q.gl_pulses == 4'h8 && !s_q.demod[`RXG_B_GL_WIN] |-> !GAIN_LOOP_RUN)
      else $error("gain loop ran past eight pulses");
   chk_s23_code: assert property (@(posedge CLK) disable iff (!RST_B)
      STAGE23_LOADED[7:4] == 4'h7 |-> AM_STAGE23.widen_steps == 4'h4 &&
      AM_STAGE23.stage_cut_steps == 4'h3)
      else $error("stage23 decode wrong");
   chk_ratio_bits: assert property (@(posedge CLK) disable iff (!RST_B)
      ##1 RX_CTL.gl_ratio_6 == s_q.demod[0] && RX_CTL.sq_ratio_6_3 == s_q.demod[4])
      else $error("ratio bits wrong");

   cov_write: cover property (@(posedge CLK) disable iff (!RST_B) BVALID && BREADY);
   cov_read: cover property (@(posedge CLK) disable iff (!RST_B) RVALID && RREADY);
   cov_squelch: cover property (@(posedge CLK) disable iff (!RST_B) $fell(SQUELCH_ACTIVE));
   cov_load: cover property (@(posedge CLK) disable iff (!RST_B) RESET_RX_GAIN_CMD);
endmodule // rxg_bank

// file: hw/rxg_params.svh
// Purpose: constants for the receiver demodulator and gain configuration bank
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: one aligned word per register, data in the low eight bits
`ifndef RXG_PARAMS_SVH
`define RXG_PARAMS_SVH
`define RXG_IDX_DEMOD 8'h0c
`define RXG_IDX_STAGE1 8'h0d
`define RXG_IDX_STAGE23 8'h0e
`define RXG_RST_DEMOD 8'h2c
`define RXG_RST_STAGE1 8'hd8
`define RXG_RST_STAGE23 8'h00
`define RXG_B_DEMOD_MODE 7
`define RXG_B_AMD_SEL 6
`define RXG_B_SQ_EN 5
`define RXG_B_SQ_RATIO 4
`define RXG_B_GL_EN 3
`define RXG_B_GL_WIN 2
`define RXG_B_GL_ALG 1
`define RXG_B_GL_RATIO 0
`define RXG_B_LOW_FREQ_INPUT_ENABLE 1
`define RXG_B_LF_SPLIT 0
`define RXG_SQ_DELAY_NS 18880
`define RXG_CLK_NS 50
`define RXG_SQ_DELAY_CYC ((`RXG_SQ_DELAY_NS + `RXG_CLK_NS - 1) / `RXG_CLK_NS)
`define RXG_GL_PULSES 8
`define RXG_STAGE23_MAX 4'ha
`define RXG_STAGE23_WIDEN_MAX 4'h4
`define RXG_RESP_OKAY 2'b00
`define RXG_RESP_SLVERR 2'b10
`endif

// file: hw/rxg_pkg.sv
// Purpose: types for the receiver configuration bank
// Assumes: rxg_params.svh holds every number
// Notes: none
package rxg_pkg;
   typedef enum logic [2:0] {
      RXG_SQ_IDLE = 3'b001,
      RXG_SQ_WAIT = 3'b010,
      RXG_SQ_ON = 3'b100
   } rxg_sq_e;

   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] am_db_tenths_idx;
   } rxg_unused_s;

   typedef struct packed {
      logic iq_mode;
      logic iq_invalid;
      logic sq_ratio_6_3;
      logic gl_active;
      logic gl_whole_frame;
      logic gl_alg_reset;
      logic gl_ratio_6;
      logic hf_route;
      logic lf_route;
      logic lf_split_ab;
   } rxg_ctl_s;

   typedef struct packed {
      logic [3:0] widen_steps;
      logic [3:0] stage_cut_steps;
      logic invalid;
   } rxg_s23_s;

   typedef struct packed {
      logic aw_hold;
      logic [7:0] aw_addr;
      logic w_hold;
      logic [7:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic [7:0] demod;
      logic [7:0] stage1;
      logic [7:0] stage23;
      logic [7:0] stage23_live;
      rxg_sq_e sq;
      logic [9:0] sq_cnt;
      logic [3:0] gl_pulses;
      logic gl_run;
   } rxg_state_s;
endpackage

// file: verif/test_rx_demod_gain_config_bank.sv
// Purpose: self-checking bench for the receiver configuration bank
// Assumes: AXI4-Lite master tasks, events driven on CLK rising edges
// Notes: stage 2/3 codes above Ah are never written
`timescale 1ns/100ps
`include "rxg_params.svh"
module test_rx_demod_gain_config_bank
   import rxg_pkg::*;
;
   localparam logic [7:0] A_DM = 8'(`RXG_IDX_DEMOD * 4);
   localparam logic [7:0] A_S1 = 8'(`RXG_IDX_STAGE1 * 4);
   localparam logic [7:0] A_S23 = 8'(`RXG_IDX_STAGE23 * 4);
   localparam logic [1:0] OK = `RXG_RESP_OKAY;
   localparam logic [1:0] SE = `RXG_RESP_SLVERR;
   logic CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA;
   logic [3:0] WSTRB;
   logic TX_END, RX_FRAME, SUBCARRIER_PULSE, SQ_STOP_MATCH, RESET_RX_GAIN_CMD;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SQUELCH_ACTIVE, GAIN_LOOP_RUN;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   rxg_ctl_s RX_CTL;
   logic [2:0] AM_STAGE1_GAIN, PM_STAGE1_GAIN;
   rxg_s23_s AM_STAGE23, PM_STAGE23;
   logic [7:0] STAGE23_LOADED;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   logic [7:0] v;

   rxg_bank uut (.CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .TX_END(TX_END), .RX_FRAME(RX_FRAME), .SUBCARRIER_PULSE(SUBCARRIER_PULSE),
      .SQ_STOP_MATCH(SQ_STOP_MATCH), .RESET_RX_GAIN_CMD(RESET_RX_GAIN_CMD),
      .SQUELCH_ACTIVE(SQUELCH_ACTIVE), .GAIN_LOOP_RUN(GAIN_LOOP_RUN), .RX_CTL(RX_CTL),
      .AM_STAGE1_GAIN(AM_STAGE1_GAIN), .PM_STAGE1_GAIN(PM_STAGE1_GAIN),
      .AM_STAGE23(AM_STAGE23), .PM_STAGE23(PM_STAGE23), .STAGE23_LOADED(STAGE23_LOADED));

   always #25 CLK = ~CLK;

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard: the whole sequence needs well under 5000 cycles
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         miscompares++;
         results();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge CLK);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     input logic [1:0] er, input bit late = 1'b0);
      logic aw, w, bv, pend;
      logic [1:0] r;
      bv = 0;
      @(posedge CLK);
      AWADDR <= a;
      AWVALID <= 1;
      WDATA <= {24'h0, d};
      WSTRB <= s;
      WVALID <= 1;
      // Late mode lets the response wait a cycle so it must stand
      BREADY <= !late;
      while (!bv) begin
         #1;
         aw = AWVALID && AWREADY;
         w = WVALID && WREADY;
         pend = (BVALID === 1'b1);
         bv = pend && (BREADY === 1'b1);
         r = BRESP;
         @(posedge CLK);
         if (aw) AWVALID <= 0;
         if (w) WVALID <= 0;
         if (bv) BREADY <= 0;
         else if (pend) BREADY <= 1;
      end
      chk(r, er, "write response");
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er,
                     input bit late = 1'b0);
      logic ar, rv, pend;
      logic [31:0] d;
      logic [1:0] r;
      rv = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1;
      RREADY <= !late;
      while (!rv) begin
         #1;
         ar = ARVALID && ARREADY;
         pend = (RVALID === 1'b1);
         rv = pend && (RREADY === 1'b1);
         d = RDATA;
         r = RRESP;
         @(posedge CLK);
         if (ar) ARVALID <= 0;
         if (rv) RREADY <= 0;
         else if (pend) RREADY <= 1;
      end
      chk(d, {24'h0, ed}, "read data");
      chk(r, er, "read response");
      #1;
   endtask

   // One-cycle strobe: 0 tx end, 1 subcarrier pulse, 2 stop match, 3 gain reload
   task automatic ev(input int k);
      @(posedge CLK);
      case (k)
         0: TX_END <= 1;
         1: SUBCARRIER_PULSE <= 1;
         2: SQ_STOP_MATCH <= 1;
         default: RESET_RX_GAIN_CMD <= 1;
      endcase
      @(posedge CLK);
      {TX_END, SUBCARRIER_PULSE, SQ_STOP_MATCH, RESET_RX_GAIN_CMD} <= 4'h0;
      #1;
   endtask

   task automatic sqwait(input int lim);
      ev(0);
      n = 0;
      while (SQUELCH_ACTIVE !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask

   initial begin
      {CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 7'h0;
      {AWADDR, ARADDR, WDATA, WSTRB} = 52'h0;
      {TX_END, RX_FRAME, SUBCARRIER_PULSE, SQ_STOP_MATCH, RESET_RX_GAIN_CMD} = 5'h0;
      tick(10);
      RST_B <= 1;
      rd(A_DM, `RXG_RST_DEMOD, OK);
      rd(A_S1, `RXG_RST_STAGE1, OK);
      rd(A_S23, `RXG_RST_STAGE23, OK);
      wr(8'h3c, 8'hff, 4'h1, SE, 1'b1);
      wr(8'h0c, 8'hff, 4'h1, SE);
      rd(A_DM, `RXG_RST_DEMOD, OK);
      rd(8'h3c, 8'h00, SE, 1'b1);
      wr(A_S1, 8'h00, 4'h0, OK);
      rd(A_S1, `RXG_RST_STAGE1, OK);
      $display("reset and access test done");
      for (int i = 0; i < 8; i++) begin
         v = 8'(8'hd1 >> i) ^ 8'(8'h2e << i);
         wr(A_DM, v, 4'h1, OK);
         chk({RX_CTL.iq_mode, RX_CTL.iq_invalid, RX_CTL.sq_ratio_6_3}, {v[7], v[7] & ~v[6], v[4]}, "demod");
         chk({RX_CTL.gl_active, RX_CTL.gl_whole_frame, RX_CTL.gl_alg_reset, RX_CTL.gl_ratio_6},
            v[3:0], "gain loop");
         rd(A_DM, v, OK);
      end
      for (int c = 0; c < 8; c++) begin
         v = {3'(c), 3'(7 - c), 2'(c)};
         wr(A_S1, v, 4'h1, OK);
         chk({AM_STAGE1_GAIN, PM_STAGE1_GAIN}, v[7:2], "stage1");
         chk({RX_CTL.hf_route, RX_CTL.lf_route, RX_CTL.lf_split_ab}, {~v[1], v[1], v[0]}, "input");
      end
      $display("decode test done");
      for (int c = 0; c <= 10; c++) begin
         v = {4'(c), 4'(10 - c)};
         wr(A_S23, v, 4'h1, OK);
         if (c > 0) chk(STAGE23_LOADED, {4'(c - 1), 4'(11 - c)}, "held");
         rd(A_S23, v, OK);
         ev(3);
         tick(1);
         chk(STAGE23_LOADED, v, "loaded");
         chk(AM_STAGE23, {4'(c > 4 ? 4 : c), 4'(c > 4 ? c - 4 : 0), 1'b0}, "am23");
         chk(PM_STAGE23, {4'(c < 6 ? 4 : 10 - c), 4'(c < 6 ? 6 - c : 0), 1'b0}, "pm23");
      end
      $display("stage 2/3 test done");
      wr(A_DM, 8'h0c, 4'h1, OK);
      sqwait(450);
      chk(n, 450, "squelch off");
      wr(A_DM, 8'h2c, 4'h1, OK);
      sqwait(450);
      chk(n, `RXG_SQ_DELAY_CYC, "squelch delay");
      ev(2);
      tick(1);
      chk(SQUELCH_ACTIVE, 1'b0, "squelch stop");
      sqwait(450);
      chk(n, `RXG_SQ_DELAY_CYC, "squelch restart");
      wr(A_DM, 8'h0c, 4'h1, OK);
      tick(1);
      chk(SQUELCH_ACTIVE, 1'b0, "squelch cleared");
      $display("squelch test done");
      for (int k = 0; k < 3; k++) begin
         v = k == 0 ? 8'h28 : (k == 1 ? 8'h2c : 8'h24);
         wr(A_DM, v, 4'h1, OK);
         RX_FRAME <= 1;
         tick(2);
         chk(GAIN_LOOP_RUN, v[3], "loop start");
         repeat (`RXG_GL_PULSES - 1) ev(1);
         chk(GAIN_LOOP_RUN, v[3], "loop before last");
         ev(1);
         tick(1);
         chk(GAIN_LOOP_RUN, v[3] & v[2], "loop window");
         RX_FRAME <= 0;
         tick(2);
         chk(GAIN_LOOP_RUN, 1'b0, "loop end");
      end
      $display("gain loop test done");
      results();
   end
endmodule // test_rx_demod_gain_config_bank
